// file: logic/rpc_edge_checker.sv
// Edge-to-edge interval checker for the bit-check phase
`timescale 1ns/1ps
`default_nettype none
module rpc_edge_checker
  import rpc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic check_tick,
  input wire logic demod_in,
  input wire rpc_chk_cfg_t cfg,
  output rpc_chk_res_t res,
  output logic [5:0] edge_interval_count
);
  logic [5:0] cnt_ff, nxt_cnt;
  logic [4:0] pass_ff, nxt_pass;
  logic prev_ff, nxt_prev;
  logic started_ff, nxt_started;
  logic edge_seen;
  logic [4:0] need;

  assign edge_seen = demod_in != prev_ff;
  assign need = rpc_checks_needed(cfg.nbit_sel);
  assign edge_interval_count = cnt_ff;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_pass = pass_ff;
    nxt_prev = demod_in;
    nxt_started = started_ff;
    res = '0;
    if (!cfg.enable) begin
      // Demod level before check start is undefined and not judged
      nxt_cnt = '0;
      nxt_pass = '0;
      nxt_started = 1'b0;
    end else if (need == 5'd0) begin
      res.pass = 1'b1;
      res.done = 1'b1;
    end else if (edge_seen && !started_ff) begin
      // First edge only opens the first interval
      nxt_started = 1'b1;
      nxt_cnt = '0;
    end else if (edge_seen) begin
      nxt_cnt = '0;
      if (cnt_ff < cfg.lim_min || cnt_ff >= cfg.lim_max) begin
        // Abort drops the tally so continuous mode restarts cleanly
        nxt_pass = '0;
        res.fail = 1'b1;
        res.done = 1'b1;
      end else begin
        nxt_pass = pass_ff + 5'd1;
        if (nxt_pass >= need) begin
          res.pass = 1'b1;
          res.done = 1'b1;
        end
      end
    end else if (started_ff && cnt_ff >= cfg.lim_max) begin
      // Next edge only opens a fresh interval
      nxt_pass = '0;
      nxt_cnt = '0;
      nxt_started = 1'b0;
      res.fail = 1'b1;
      res.done = 1'b1;
    end else if (started_ff && check_tick) begin
      nxt_cnt = cnt_ff + 6'd1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= '0;
      pass_ff <= '0;
      prev_ff <= 1'b0;
      started_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      pass_ff <= nxt_pass;
      prev_ff <= nxt_prev;
      started_ff <= nxt_started;
    end
  end

  a_fail_low_limit: assert property (@(posedge hclk) disable iff (!hresetn)
    (cfg.enable && started_ff && edge_seen && need != 0 && cnt_ff < cfg.lim_min) |-> res.fail)
    else $error("short interval not failed");
  a_fail_upper: assert property (@(posedge hclk) disable iff (!hresetn)
    (cfg.enable && started_ff && !edge_seen && need != 0 && cnt_ff >= cfg.lim_max) |-> res.fail)
    else $error("upper limit reached without fail");
  a_no_pass_early: assert property (@(posedge hclk) disable iff (!hresetn)
    (res.pass && need != 0) |-> (pass_ff + 5'd1 >= need))
    else $error("pass before enough checks");
endmodule : rpc_edge_checker
`default_nettype wire

// file: logic/rpc_pkg.sv
// Package: constants, register map and carrier types of the RX polling bit-check block
// Contract
// - Sleep lasts sleep field times 1024 base ticks, times the extension factor.
// - Extension factor is 1 when sleep-extend is 0, 8 when it is 1.
// - Start-up enables PLL, waits for lock, then settles signal processing.
// - Bit-check compares edge intervals to a window, up to a programmed count.
// - Check-bit setting selects 0, 3, 6 or 9 bits: 0, 6, 12, 18 checks.
// - Interval inside window continues; outside it aborts to sleep. Code: only polling mode sleeps, continuous mode returns to bit-check.
// - Lower window is lower limit ticks; upper is upper limit minus one ticks.
// - Lower limit is six bits of control 5, upper six bits of control 6.
// - Interval counter advances per check tick; start-up demod output ignored.
// - Fail at edge below lower limit, or when counter reaches upper limit.
// - After all bits pass, enter receive and set clock-output-enable bit.
// - Interrupt on receive entry only if transparent and pattern selects are 0.
// - Transparent select 1 with chip select inactive drives data onto serial out.
// - Transparent select 0 sends received data to the buffer path.
// - Polling loops sleep, start-up, bit-check until a bit-check succeeds.
// - Mode code 010 is polling receive, 011 is continuous receive.
package rpc_pkg;
  localparam logic [31:0] RPC_ADDR_CTRL1 = 32'h0000_0004;
  localparam logic [31:0] RPC_ADDR_CTRL3 = 32'h0000_000C;
  localparam logic [31:0] RPC_ADDR_CTRL4 = 32'h0000_0010;
  localparam logic [31:0] RPC_ADDR_CTRL5 = 32'h0000_0014;
  localparam logic [31:0] RPC_ADDR_CTRL6 = 32'h0000_0018;
  localparam logic [31:0] RPC_ADDR_STAT = 32'h0000_0020;
  localparam logic [31:0] RPC_ADDR_IRQ_STAT = 32'h0000_0024;
  localparam logic [31:0] RPC_ADDR_IRQ_MASK = 32'h0000_0028;
  // Control 1: mode bits [2:0], transparent [3], pattern [4]
  localparam int RPC_OPM_LSB = 0;
  localparam int RPC_TMODE_BIT = 3;
  localparam int RPC_PMODE_BIT = 4;
  // Control 3: clock output enable [0]
  localparam int RPC_CLKON_BIT = 0;
  // Control 4: sleep [4:0], sleep extend [5]
  localparam int RPC_SLEEP_LSB = 0;
  localparam int RPC_XSLEEP_BIT = 5;
  // Control 5: lower limit [5:0], check bits [7:6]; control 6: upper limit [5:0]
  localparam int RPC_LIM_LSB = 0;
  localparam int RPC_NBIT_LSB = 6;
  // Interrupt status/mask bits
  localparam int RPC_IRQ_RX_BIT = 0;
  localparam int RPC_IRQ_FAIL_BIT = 1;
  localparam logic [2:0] RPC_OPM_POLL = 3'h2;
  localparam logic [2:0] RPC_OPM_RXCONT = 3'h3;
  localparam logic [15:0] RPC_SLEEP_UNIT = 16'h0400;
  localparam logic [3:0] RPC_XSLEEP_FACTOR = 4'h8;
  localparam logic [7:0] RPC_CTRL1_RST = 8'h00;
  localparam logic [7:0] RPC_CTRL4_RST = 8'h01;
  localparam logic [7:0] RPC_CTRL5_RST = 8'h4E;
  localparam logic [7:0] RPC_CTRL6_RST = 8'h18;

  typedef enum {RPC_ST_IDLE, RPC_ST_SLEEP, RPC_ST_PLL, RPC_ST_SIG, RPC_ST_CHECK, RPC_ST_RECV} rpc_state_t;

  typedef struct packed {
    logic [5:0] lim_min;
    logic [5:0] lim_max;
    logic [1:0] nbit_sel;
    logic enable;
  } rpc_chk_cfg_t;

  typedef struct packed {
    logic pass;
    logic fail;
    logic done;
  } rpc_chk_res_t;

  // Edge checks needed for a check-bit setting: two per bit
  function automatic logic [4:0] rpc_checks_needed(input logic [1:0] sel);
    case (sel)
      2'd0: rpc_checks_needed = 5'd0;
      2'd1: rpc_checks_needed = 5'd6;
      2'd2: rpc_checks_needed = 5'd12;
      default: rpc_checks_needed = 5'd18;
    endcase
  endfunction : rpc_checks_needed
endpackage : rpc_pkg

// file: logic/rpc_polling_seq.sv
// RX polling sequencer with AHB-Lite registers and interrupt
`timescale 1ns/1ps
`default_nettype none
module rpc_polling_seq
  import rpc_pkg::*;
#(
  parameter int SIG_SETTLE_TICKS = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic base_tick,
  input wire logic check_tick,
  input wire logic demod_in,
  input wire logic pll_lock,
  input wire logic cs_active,
  output logic pll_en,
  output logic sig_proc_en,
  output logic rx_active,
  output logic clk_out_en,
  output logic serial_out_pin,
  output logic serial_out_oe,
  output logic buf_data,
  output logic buf_valid,
  output logic irq
);
  if (SIG_SETTLE_TICKS < 1 || SIG_SETTLE_TICKS > 65535) begin : g_bad_settle
    $error("SIG_SETTLE_TICKS out of range");
  end

  rpc_state_t st_ff, nxt_st;
  // One timer serves sleep and settling; the phases never overlap
  logic [18:0] tmr_ff, nxt_tmr;
  logic [7:0] ctrl1_ff, ctrl3_ff, ctrl4_ff, ctrl5_ff, ctrl6_ff;
  logic [7:0] nxt_ctrl1, nxt_ctrl3, nxt_ctrl4, nxt_ctrl5, nxt_ctrl6;
  logic [1:0] ist_ff, nxt_ist, imask_ff, nxt_imask;
  logic wpend_ff, nxt_wpend;
  logic [31:0] waddr_ff, nxt_waddr;
  logic [31:0] rdata_ff, nxt_rdata;
  logic sout_ff, nxt_sout, soe_ff, nxt_soe, bdat_ff, nxt_bdat, bval_ff, nxt_bval;
  rpc_chk_cfg_t chk_cfg;
  rpc_chk_res_t chk_res;
  logic [5:0] ei_count;
  logic [2:0] opm;
  logic in_rx_mode, rx_enter, fail_ev, ctrl_write, addr_ok;
  logic [18:0] sleep_len;

  assign opm = ctrl1_ff[RPC_OPM_LSB +: 3];
  assign in_rx_mode = (opm == RPC_OPM_POLL) || (opm == RPC_OPM_RXCONT);
  // Sleep length, extended eightfold when requested
  assign sleep_len = 19'(ctrl4_ff[RPC_SLEEP_LSB +: 5]) * 19'(RPC_SLEEP_UNIT)
                   * (ctrl4_ff[RPC_XSLEEP_BIT] ? 19'(RPC_XSLEEP_FACTOR) : 19'd1);

  assign chk_cfg.lim_min = ctrl5_ff[RPC_LIM_LSB +: 6];
  assign chk_cfg.lim_max = ctrl6_ff[RPC_LIM_LSB +: 6];
  assign chk_cfg.nbit_sel = ctrl5_ff[RPC_NBIT_LSB +: 2];
  assign chk_cfg.enable = st_ff == RPC_ST_CHECK;

  rpc_edge_checker u_chk (
    .hclk(hclk),
    .hresetn(hresetn),
    .check_tick(check_tick),
    .demod_in(demod_in),
    .cfg(chk_cfg),
    .res(chk_res),
    .edge_interval_count(ei_count)
  );

  function automatic logic rpc_addr_valid(input logic [31:0] a);
    rpc_addr_valid = a == RPC_ADDR_CTRL1 || a == RPC_ADDR_CTRL3 || a == RPC_ADDR_CTRL4
                  || a == RPC_ADDR_CTRL5 || a == RPC_ADDR_CTRL6 || a == RPC_ADDR_STAT
                  || a == RPC_ADDR_IRQ_STAT || a == RPC_ADDR_IRQ_MASK;
  endfunction : rpc_addr_valid

  assign addr_ok = rpc_addr_valid(waddr_ff);
  assign ctrl_write = wpend_ff && (waddr_ff == RPC_ADDR_CTRL1 || waddr_ff == RPC_ADDR_CTRL4
                      || waddr_ff == RPC_ADDR_CTRL5 || waddr_ff == RPC_ADDR_CTRL6);
  assign rx_enter = (st_ff == RPC_ST_CHECK) && chk_res.pass;
  assign fail_ev = (st_ff == RPC_ST_CHECK) && chk_res.fail;

  // Sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_tmr = tmr_ff;
    case (st_ff)
      RPC_ST_IDLE: begin
        if (opm == RPC_OPM_POLL) begin
          nxt_st = RPC_ST_SLEEP;
          nxt_tmr = '0;
        end else if (opm == RPC_OPM_RXCONT) begin
          nxt_st = RPC_ST_PLL;
        end
      end
      RPC_ST_SLEEP: begin
        if (tmr_ff >= sleep_len) begin
          nxt_st = RPC_ST_PLL;
        end else if (base_tick) begin
          nxt_tmr = tmr_ff + 19'd1;
        end
      end
      RPC_ST_PLL: begin
        if (pll_lock) begin
          nxt_st = RPC_ST_SIG;
          nxt_tmr = '0;
        end
      end
      RPC_ST_SIG: begin
        if (tmr_ff >= 19'(SIG_SETTLE_TICKS)) begin
          nxt_st = RPC_ST_CHECK;
        end else if (base_tick) begin
          nxt_tmr = tmr_ff + 19'd1;
        end
      end
      RPC_ST_CHECK: begin
        if (chk_res.pass) begin
          nxt_st = RPC_ST_RECV;
        end else if (chk_res.fail) begin
          // Continuous mode restarts checking; polling sleeps again
          nxt_st = (opm == RPC_OPM_POLL) ? RPC_ST_SLEEP : RPC_ST_CHECK;
          nxt_tmr = '0;
        end
      end
      RPC_ST_RECV: begin
        // Writes to control 1, 4, 5 or 6 restart the receive path through signal start-up
        if (ctrl_write) begin
          nxt_st = RPC_ST_SIG;
          nxt_tmr = '0;
        end
      end
      default: nxt_st = RPC_ST_IDLE;
    endcase
    if (!in_rx_mode) begin
      nxt_st = RPC_ST_IDLE;
    end
  end

  // Bus slave: zero wait state, write data captured in data phase
  always_comb begin
    nxt_wpend = 1'b0;
    nxt_waddr = waddr_ff;
    nxt_rdata = rdata_ff;
    nxt_ctrl1 = ctrl1_ff;
    nxt_ctrl3 = ctrl3_ff;
    nxt_ctrl4 = ctrl4_ff;
    nxt_ctrl5 = ctrl5_ff;
    nxt_ctrl6 = ctrl6_ff;
    nxt_imask = imask_ff;
    nxt_ist = ist_ff;
    if (wpend_ff && addr_ok) begin
      case (waddr_ff)
        RPC_ADDR_CTRL1: nxt_ctrl1 = hwdata[7:0];
        RPC_ADDR_CTRL3: nxt_ctrl3 = hwdata[7:0];
        RPC_ADDR_CTRL4: nxt_ctrl4 = hwdata[7:0];
        RPC_ADDR_CTRL5: nxt_ctrl5 = hwdata[7:0];
        RPC_ADDR_CTRL6: nxt_ctrl6 = hwdata[7:0];
        RPC_ADDR_IRQ_STAT: nxt_ist = ist_ff & ~hwdata[1:0];
        RPC_ADDR_IRQ_MASK: nxt_imask = hwdata[1:0];
        default: nxt_ist = nxt_ist;
      endcase
    end
    // Hardware set wins over a write-one clear in the same cycle
    if (rx_enter && !ctrl1_ff[RPC_TMODE_BIT] && !ctrl1_ff[RPC_PMODE_BIT]) begin
      nxt_ist[RPC_IRQ_RX_BIT] = 1'b1;
    end
    if (fail_ev) begin
      nxt_ist[RPC_IRQ_FAIL_BIT] = 1'b1;
    end
    if (rx_enter) begin
      nxt_ctrl3[RPC_CLKON_BIT] = 1'b1;
    end
    if (hsel && hready && htrans[1]) begin
      nxt_waddr = haddr;
      nxt_wpend = hwrite;
      case (haddr)
        RPC_ADDR_CTRL1: nxt_rdata = {24'h0000_00, ctrl1_ff};
        RPC_ADDR_CTRL3: nxt_rdata = {24'h0000_00, ctrl3_ff};
        RPC_ADDR_CTRL4: nxt_rdata = {24'h0000_00, ctrl4_ff};
        RPC_ADDR_CTRL5: nxt_rdata = {24'h0000_00, ctrl5_ff};
        RPC_ADDR_CTRL6: nxt_rdata = {24'h0000_00, ctrl6_ff};
        RPC_ADDR_STAT: nxt_rdata = {20'h0_0000, ei_count, 3'(st_ff), rx_active, pll_en, sig_proc_en};
        RPC_ADDR_IRQ_STAT: nxt_rdata = {30'h0000_0000, ist_ff};
        RPC_ADDR_IRQ_MASK: nxt_rdata = {30'h0000_0000, imask_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Data routing in receiving mode
  always_comb begin
    nxt_sout = 1'b0;
    nxt_soe = 1'b0;
    nxt_bdat = 1'b0;
    nxt_bval = 1'b0;
    if (st_ff == RPC_ST_RECV) begin
      if (ctrl1_ff[RPC_TMODE_BIT] && !cs_active) begin
        nxt_sout = demod_in;
        nxt_soe = 1'b1;
      end else if (!ctrl1_ff[RPC_TMODE_BIT]) begin
        nxt_bdat = demod_in;
        nxt_bval = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= RPC_ST_IDLE;
      tmr_ff <= '0;
      ctrl1_ff <= RPC_CTRL1_RST;
      ctrl3_ff <= 8'h00;
      ctrl4_ff <= RPC_CTRL4_RST;
      ctrl5_ff <= RPC_CTRL5_RST;
      ctrl6_ff <= RPC_CTRL6_RST;
      ist_ff <= '0;
      imask_ff <= '0;
      wpend_ff <= 1'b0;
      waddr_ff <= '0;
      rdata_ff <= '0;
      sout_ff <= 1'b0;
      soe_ff <= 1'b0;
      bdat_ff <= 1'b0;
      bval_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      tmr_ff <= nxt_tmr;
      ctrl1_ff <= nxt_ctrl1;
      ctrl3_ff <= nxt_ctrl3;
      ctrl4_ff <= nxt_ctrl4;
      ctrl5_ff <= nxt_ctrl5;
      ctrl6_ff <= nxt_ctrl6;
      ist_ff <= nxt_ist;
      imask_ff <= nxt_imask;
      wpend_ff <= nxt_wpend;
      waddr_ff <= nxt_waddr;
      rdata_ff <= nxt_rdata;
      sout_ff <= nxt_sout;
      soe_ff <= nxt_soe;
      bdat_ff <= nxt_bdat;
      bval_ff <= nxt_bval;
    end
  end

  assign hrdata = rdata_ff;
  // No wait states: every register answers in the data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign pll_en = st_ff inside {RPC_ST_PLL, RPC_ST_SIG, RPC_ST_CHECK, RPC_ST_RECV};
  assign sig_proc_en = st_ff inside {RPC_ST_SIG, RPC_ST_CHECK, RPC_ST_RECV};
  assign rx_active = st_ff != RPC_ST_IDLE && st_ff != RPC_ST_SLEEP;
  assign clk_out_en = ctrl3_ff[RPC_CLKON_BIT];
  assign serial_out_pin = sout_ff;
  assign serial_out_oe = soe_ff;
  assign buf_data = bdat_ff;
  assign buf_valid = bval_ff;
  assign irq = |(ist_ff & imask_ff);

  a_sig_after_lock: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff == RPC_ST_SIG && $past(st_ff) == RPC_ST_PLL) |-> $past(pll_lock))
    else $error("signal processing before lock");
  a_lock_to_sig: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff == RPC_ST_PLL && pll_lock && in_rx_mode) |=> st_ff == RPC_ST_SIG)
    else $error("lock not followed by settling");
  a_fail_to_sleep: assert property (@(posedge hclk) disable iff (!hresetn)
    (fail_ev && !chk_res.pass && opm == RPC_OPM_POLL) |=> st_ff == RPC_ST_SLEEP)
    else $error("failed check did not sleep");
  a_pass_clk_on: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_enter |=> (st_ff == RPC_ST_RECV || !in_rx_mode) && clk_out_en)
    else $error("receive entry without clock enable");
  a_irq_gated: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_enter && (ctrl1_ff[RPC_TMODE_BIT] || ctrl1_ff[RPC_PMODE_BIT]) && !ist_ff[RPC_IRQ_RX_BIT])
    |=> !ist_ff[RPC_IRQ_RX_BIT])
    else $error("receive irq despite select bits");
  a_sleep_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff == RPC_ST_SLEEP) |-> tmr_ff <= sleep_len)
    else $error("sleep timer overran");
  a_transparent: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff == RPC_ST_RECV && ctrl1_ff[RPC_TMODE_BIT] && !cs_active && in_rx_mode)
    |=> serial_out_oe && serial_out_pin == $past(demod_in))
    else $error("transparent output missing");
  a_buffer_path: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff == RPC_ST_RECV && !ctrl1_ff[RPC_TMODE_BIT]) |=> buf_valid && !serial_out_oe)
    else $error("buffer path missing");
  a_fail_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    fail_ev |=> ist_ff[RPC_IRQ_FAIL_BIT])
    else $error("check fail not flagged");
  a_mode_exit: assert property (@(posedge hclk) disable iff (!hresetn)
    !in_rx_mode |=> st_ff == RPC_ST_IDLE)
    else $error("sequencer active outside receive modes");
  a_sleep_to_pll: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff == RPC_ST_SLEEP && tmr_ff >= sleep_len && in_rx_mode) |=> st_ff == RPC_ST_PLL)
    else $error("sleep did not end in start-up");
  a_recv_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff == RPC_ST_RECV && in_rx_mode && !ctrl_write) |=> st_ff == RPC_ST_RECV)
    else $error("receive left without cause");
endmodule : rpc_polling_seq
`default_nettype wire

// file: testbench/rpc_demod_model.sv
// Demodulator, PLL-lock and tick source model for the polling block
`timescale 1ns/1ps
`default_nettype none
module rpc_demod_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pll_en,
  input wire logic run,
  input wire logic [7:0] half,
  input wire logic [7:0] n_edges,
  output logic base_tick,
  output logic check_tick,
  output logic pll_lock,
  output logic demod_in
);
  logic [7:0] cnt_ff;
  logic [7:0] edges_ff;
  logic [3:0] lock_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base_tick <= 1'b0;
      check_tick <= 1'b0;
      lock_ff <= 4'h0;
      cnt_ff <= 8'h00;
      edges_ff <= 8'h00;
      demod_in <= 1'b0;
    end else begin
      base_tick <= ~base_tick;
      check_tick <= ~check_tick;
      lock_ff <= pll_en ? lock_ff + {3'h0, lock_ff != 4'hF} : 4'h0;
      if (!run) begin
        cnt_ff <= 8'h00;
        edges_ff <= 8'h00;
      end else if (cnt_ff == half - 8'h01) begin
        cnt_ff <= 8'h00;
        // Edge budget lets a burst stop short of the needed count
        if (n_edges == 8'h00 || edges_ff < n_edges) begin
          demod_in <= ~demod_in;
          edges_ff <= edges_ff + 8'h01;
        end
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end
  // Lock only after several cycles, never before the PLL is enabled
  assign pll_lock = pll_en && lock_ff == 4'hF;
endmodule : rpc_demod_model
`default_nettype wire

// file: testbench/tb_rx_polling_bit_check.sv
// Self-checking bench for the RX polling bit-check block
`timescale 1ns/1ps
`default_nettype none
module tb_rx_polling_bit_check;
  import rpc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, cs_active, run;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] half, n_edges;
  logic hreadyout, hresp, base_tick, check_tick, demod_in, pll_lock, pll_en, sig_proc_en;
  logic rx_active, clk_out_en, serial_out_pin, serial_out_oe, buf_data, buf_valid, irq;
  logic [3:0] mon;
  int failures, cmp_count;
  int cyc = 0;
  assign mon = {irq, clk_out_en, sig_proc_en, pll_en};
  rpc_polling_seq #(.SIG_SETTLE_TICKS(1)) rpc_polling_seq_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .base_tick(base_tick),
    .check_tick(check_tick), .demod_in(demod_in), .pll_lock(pll_lock), .cs_active(cs_active),
    .pll_en(pll_en), .sig_proc_en(sig_proc_en), .rx_active(rx_active), .clk_out_en(clk_out_en),
    .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe), .buf_data(buf_data),
    .buf_valid(buf_valid), .irq(irq));
  rpc_demod_model rpc_demod_model_i (.hclk(hclk), .hresetn(hresetn), .pll_en(pll_en), .run(run),
    .half(half), .n_edges(n_edges), .base_tick(base_tick), .check_tick(check_tick),
    .pll_lock(pll_lock), .demod_in(demod_in));
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) cyc <= cyc + 1;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wait_bit(input int i, input int lim);
    int n;
    n = 0;
    while (mon[i] !== 1'b1) begin
      n++;
      if (n > lim) begin
        failures++;
        $display("unexpected timeout: expected %0d seen %0d", i, n);
        print_verdict();
      end
      @(posedge hclk);
    end
  endtask : wait_bit

  task automatic edge_wait();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        failures++;
        $display("unexpected hreadyout: expected 1 seen 0 for %0d cycles", n);
        print_verdict();
      end
      @(posedge hclk);
    end
  endtask : edge_wait

  // Single word transfer; read data lands in q
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    edge_wait();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    edge_wait();
    q = hrdata;
  endtask : bus

  task automatic wait_state(input logic [2:0] st);
    int n;
    n = 0;
    bus(1'b0, RPC_ADDR_STAT, 32'h0);
    while (q[5:3] !== st) begin
      n++;
      if (n > 3000) begin
        failures++;
        $display("unexpected state: expected %0d seen %0d", st, q[5:3]);
        print_verdict();
      end
      bus(1'b0, RPC_ADDR_STAT, 32'h0);
    end
  endtask : wait_state

  task automatic t_reset();
    logic [31:0] a [5] = '{RPC_ADDR_CTRL1, RPC_ADDR_CTRL4, RPC_ADDR_CTRL5, RPC_ADDR_CTRL6, 32'h40};
    logic [7:0] e [5] = '{RPC_CTRL1_RST, RPC_CTRL4_RST, RPC_CTRL5_RST, RPC_CTRL6_RST, 8'h00};
    bus(1'b1, 32'h40, 32'hFF);
    chk("bus response", 32'h0, 32'(hresp));
    foreach (a[k]) begin
      bus(1'b0, a[k], 32'h0);
      chk("reset value", 32'(e[k]), q);
    end
  endtask : t_reset

  task automatic t_sleep(input logic x, input int lo, input int hi);
    int t0;
    bus(1'b1, RPC_ADDR_CTRL4, {26'h0, x, 5'h01});
    bus(1'b1, RPC_ADDR_CTRL1, 32'(RPC_OPM_POLL));
    t0 = cyc;
    wait_bit(0, 20000);
    chk("sleep span", 32'h1, 32'(cyc - t0 >= lo && cyc - t0 <= hi));
    chk("sig before lock", 32'h0, 32'(sig_proc_en));
    chk("rx active", 32'h1, 32'(rx_active));
    wait_bit(1, 200);
    chk("lock at sig start", 32'h1, 32'(pll_lock));
    bus(1'b1, RPC_ADDR_CTRL1, 32'h0);
    wait_state(3'h0);
  endtask : t_sleep

  task automatic t_fail(input logic [2:0] m, input logic [7:0] h, input logic [2:0] st);
    bus(1'b1, RPC_ADDR_CTRL4, 32'h1);
    bus(1'b1, RPC_ADDR_CTRL1, 32'(m));
    wait_state(3'h4);
    half <= h;
    run <= 1'b1;
    wait_bit(3, 3000);
    bus(1'b0, RPC_ADDR_IRQ_STAT, 32'h0);
    chk("fail status", 32'h2, q);
    wait_state(st);
    run <= 1'b0;
    bus(1'b1, RPC_ADDR_CTRL1, 32'h0);
    bus(1'b1, RPC_ADDR_IRQ_STAT, 32'h3);
    bus(1'b0, RPC_ADDR_IRQ_STAT, 32'h0);
    chk("irq cleared", 32'h0, 32'(irq));
  endtask : t_fail

  task automatic t_pass(input logic [1:0] sel, input logic tm, input logic pm, input logic [7:0] h,
      input logic [7:0] ne, input logic ok);
    logic d;
    bus(1'b1, RPC_ADDR_CTRL5, {24'h0, sel, 6'h0E});
    bus(1'b1, RPC_ADDR_CTRL6, 32'h18);
    bus(1'b1, RPC_ADDR_CTRL1, {27'h0, pm, tm, RPC_OPM_RXCONT});
    // With no bits to check the check state lasts a single cycle
    if (sel != 2'h0) wait_state(3'h4);
    half <= h;
    n_edges <= ne;
    run <= 1'b1;
    wait_bit(ok ? 2 : 3, 3000);
    bus(1'b0, RPC_ADDR_CTRL3, 32'h0);
    chk("clock enable", 32'(ok), q);
    bus(1'b0, RPC_ADDR_IRQ_STAT, 32'h0);
    chk("rx status", ok ? 32'(!tm && !pm) : 32'h2, q);
    chk("irq pin", 32'(!ok || (!tm && !pm)), 32'(irq));
    if (ok && tm) begin
      // Several samples so a stuck output cannot match by luck
      repeat (40) begin
        d = demod_in;
        @(posedge hclk);
        chk("transparent data", 32'(d), 32'(serial_out_pin));
      end
      chk("transparent enable", 32'h1, 32'(serial_out_oe));
      cs_active <= 1'b1;
      repeat (3) @(posedge hclk);
      chk("enable under select", 32'h0, 32'(serial_out_oe));
      cs_active <= 1'b0;
    end else begin
      d = demod_in;
      @(posedge hclk);
      chk("buffered data", 32'(ok && d), 32'(buf_data));
      chk("buffer valid", 32'(ok), 32'(buf_valid));
      chk("buffered enable", 32'h0, 32'(serial_out_oe));
    end
    run <= 1'b0;
    bus(1'b1, RPC_ADDR_CTRL1, 32'h0);
    bus(1'b1, RPC_ADDR_CTRL3, 32'h0);
    bus(1'b1, RPC_ADDR_IRQ_STAT, 32'h3);
    wait_state(3'h0);
  endtask : t_pass

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    cs_active = 1'b0;
    run = 1'b0;
    half = 8'h20;
    n_edges = 8'h00;
    failures = 0;
    cmp_count = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    bus(1'b1, RPC_ADDR_IRQ_MASK, 32'h3);
    t_sleep(1'b0, 2040, 2070);
    t_sleep(1'b1, 16376, 16420);
    t_fail(RPC_OPM_POLL, 8'h1A, 3'h1);
    t_fail(RPC_OPM_RXCONT, 8'h32, 3'h4);
    t_pass(2'h1, 1'b0, 1'b0, 8'h1E, 8'h07, 1'b1);
    t_pass(2'h1, 1'b0, 1'b0, 8'h1E, 8'h06, 1'b0);
    t_pass(2'h0, 1'b0, 1'b1, 8'h2E, 8'h00, 1'b1);
    t_pass(2'h2, 1'b1, 1'b0, 8'h20, 8'h00, 1'b1);
    t_pass(2'h3, 1'b1, 1'b1, 8'h20, 8'h00, 1'b1);
    print_verdict();
  end
endmodule : tb_rx_polling_bit_check
`default_nettype wire
